/* hw/t16_regs.svh */
// Purpose: Addresses, field positions and constants of the 16-bit timer
// Assumes: 8-bit I/O register bus, one byte per address
// Notes:   Definitions only
`ifndef T16_REGS_SVH
`define T16_REGS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define T16_ADDR_FLAGS  8'h36
`define T16_ADDR_GTC    8'h43
`define T16_ADDR_MASK   8'h6f
`define T16_ADDR_CTRL   8'h81
`define T16_ADDR_CNT_LO 8'h84
`define T16_ADDR_CNT_HI 8'h85
`define T16_ADDR_CMP_LO 8'h88
`define T16_ADDR_CMP_HI 8'h89

// ----------------------------------------
// Field positions
// ----------------------------------------
`define T16_CTRL_CTC    3
`define T16_BIT_CMP     1
`define T16_BIT_OVF     0
`define T16_GTC_SYNC    7
`define T16_GTC_PSR     0

// ----------------------------------------
// Clock select codes and prescaler taps
// ----------------------------------------
`define T16_CS_STOP     3'h0
`define T16_CS_DIV1     3'h1
`define T16_CS_DIV8     3'h2
`define T16_CS_DIV32    3'h3
`define T16_CS_DIV64    3'h4
`define T16_CS_DIV128   3'h5
`define T16_CS_DIV256   3'h6
`define T16_CS_DIV1024  3'h7
`define T16_CS_EXT_FALL 3'h6
`define T16_CS_EXT_RISE 3'h7
`define T16_PS_ZERO     10'h000
`define T16_PS_ONE      10'h001
`define T16_PS_MASK8    10'h007
`define T16_PS_MASK32   10'h01f
`define T16_PS_MASK64   10'h03f
`define T16_PS_MASK128  10'h07f
`define T16_PS_MASK256  10'h0ff
`define T16_PS_MASK1024 10'h3ff

// ----------------------------------------
// Data constants
// ----------------------------------------
`define T16_CNT_MAX     16'hffff
`define T16_CNT_ZERO    16'h0000
`define T16_CNT_ONE     16'h0001
`define T16_BYTE_ZERO   8'h00

`endif

/* hw/t16_pkg.sv */
// Purpose: Types and shared tap decode of the 16-bit timer
// Assumes: Constants from t16_regs.svh
// Notes:   Tap decode serves both timers on the shared prescaler
`include "t16_regs.svh"

package t16_pkg;

    // ----------------------------------------
    // Bus request carrier
    // ----------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } t16_bus_t;

    // ----------------------------------------
    // Clock select to tick
    // ----------------------------------------
    function automatic logic t16_tap(
        input logic [2:0] sel,
        input logic [9:0] ps,
        input logic       ps_run,
        input logic       ext_mode,
        input logic       ext_rise,
        input logic       ext_fall
    );
        logic [9:0] m;
        logic       t;
        m = `T16_PS_ZERO;
        t = 1'b0;
        unique case (sel)
            `T16_CS_STOP:    t = 1'b0;
            `T16_CS_DIV1:    t = 1'b1;
            `T16_CS_DIV8:    m = `T16_PS_MASK8;
            `T16_CS_DIV32:   m = `T16_PS_MASK32;
            `T16_CS_DIV64:   m = `T16_PS_MASK64;
            `T16_CS_DIV128:  m = `T16_PS_MASK128;
            `T16_CS_DIV256:  m = `T16_PS_MASK256;
            `T16_CS_DIV1024: m = `T16_PS_MASK1024;
        endcase
        if (m != `T16_PS_ZERO) begin
            t = ps_run && ((ps & m) == m);
        end
        // External source never goes through the divider
        if (ext_mode && sel == `T16_CS_EXT_RISE) begin
            t = ext_rise;
        end
        if (ext_mode && sel == `T16_CS_EXT_FALL) begin
            t = ext_fall;
        end
        return t;
    endfunction

endpackage

/* hw/t16_prescaler.sv */
// Purpose: Free-running prescaler shared by the 16-bit and 8-bit timers
// Assumes: Reset request held high keeps the divider at zero
// Notes:   Each timer keeps its own clock select

module t16_prescaler
    import t16_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       psr,
    input  wire logic [2:0] sel16,
    input  wire logic [2:0] sel8,
    input  wire logic       ext_rise,
    input  wire logic       ext_fall,
    output logic            tick16,
    output logic            tick8
);

    logic [9:0] ps_r;

    // ----------------------------------------
    // Divider, runs whatever the selects say
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ps_r <= `T16_PS_ZERO;
        end else if (psr) begin
            ps_r <= `T16_PS_ZERO;
        end else begin
            ps_r <= ps_r + `T16_PS_ONE;
        end
    end

    // One divider, two independent taps
    assign tick16 = t16_tap(sel16, ps_r, !psr, 1'b0, 1'b0, 1'b0);
    assign tick8  = t16_tap(sel8, ps_r, !psr, 1'b1, ext_rise, ext_fall);

endmodule

/* hw/t16_ext_sync.sv */
// Purpose: Synchroniser and edge detector for the external count pin
// Assumes: Pin half periods longer than one system clock
// Notes:   Falling-edge stage stands in for a latch open while mclk is high

module t16_ext_sync (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic pin,
    output logic      rise,
    output logic      fall
);

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    logic agree;

    // ----------------------------------------
    // Sampling chain
    // ----------------------------------------
    always_ff @(negedge mclk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= 1'b0;
        end else begin
            s1_r <= pin;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // ----------------------------------------
    // Edge detector
    // ----------------------------------------
    // A level counts once two stages agree; glitch shorter than a clock is lost
    assign agree = (s2_r == s3_r);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lvl_r <= 1'b0;
        end else if (agree) begin
            lvl_r <= s3_r;
        end
    end

    assign rise = agree && s3_r && !lvl_r;
    assign fall = agree && !s3_r && lvl_r;

    a_ext_single: assert property (@(posedge mclk) disable iff (!rstn)
        (rise || fall) |=> !(rise || fall))
        else $error("external edge gave more than one tick");

endmodule

/* hw/t16_timer.sv */
// Purpose: 16-bit timer with one compare channel and the shared prescaler
// Assumes: Same-clock CPU bus; vector-done strobes are one-cycle pulses
// Notes:   Read data appears the cycle after the read strobe

module t16_timer
    import t16_pkg::*;
(
    input  wire logic     mclk,
    input  wire logic     rstn,
    input  wire t16_bus_t bus,
    input  wire logic     global_irq_en,
    input  wire logic     cmp_vector_done,
    input  wire logic     ovf_vector_done,
    input  wire logic     external_count_pin,
    input  wire logic [2:0] sib_clock_select,
    output logic [7:0]    rdata_r,
    output logic          cmp_irq_r,
    output logic          ovf_irq_r,
    output logic          sib_tick_r
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic logic hit(input logic strobe, input logic [7:0] a,
                                 input logic [7:0] want);
        return strobe && (a == want);
    endfunction

    logic wr_flags;
    logic wr_gtc;
    logic wr_mask;
    logic wr_ctrl;
    logic wr_cnt_lo;
    logic wr_cnt_hi;
    logic wr_cmp_lo;
    logic wr_cmp_hi;
    logic rd_cnt_lo;

    assign wr_flags  = hit(bus.wr, bus.addr, `T16_ADDR_FLAGS);
    assign wr_gtc    = hit(bus.wr, bus.addr, `T16_ADDR_GTC);
    assign wr_mask   = hit(bus.wr, bus.addr, `T16_ADDR_MASK);
    assign wr_ctrl   = hit(bus.wr, bus.addr, `T16_ADDR_CTRL);
    assign wr_cnt_lo = hit(bus.wr, bus.addr, `T16_ADDR_CNT_LO);
    assign wr_cnt_hi = hit(bus.wr, bus.addr, `T16_ADDR_CNT_HI);
    assign wr_cmp_lo = hit(bus.wr, bus.addr, `T16_ADDR_CMP_LO);
    assign wr_cmp_hi = hit(bus.wr, bus.addr, `T16_ADDR_CMP_HI);
    assign rd_cnt_lo = hit(bus.rd, bus.addr, `T16_ADDR_CNT_LO);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [3:0]  ctrl_r;
    logic [1:0]  mask_r;
    logic [1:0]  flags_r;
    logic [15:0] cnt_r;
    logic [15:0] cmp_r;
    logic [7:0]  temp_r;
    logic        tsm_r;
    logic        psr_r;
    logic        block_r;
    logic        tick16;
    logic        tick8;
    logic        ext_rise;
    logic        ext_fall;
    logic        equal;
    logic        match;
    logic        ctc_clear;
    logic        cmp_set;
    logic        ovf_set;
    logic [1:0]  flags_nxt;

    // ----------------------------------------
    // Clock sources
    // ----------------------------------------
    t16_ext_sync u_ext_sync (
        .mclk (mclk),
        .rstn (rstn),
        .pin  (external_count_pin),
        .rise (ext_rise),
        .fall (ext_fall)
    );

    t16_prescaler u_prescaler (
        .mclk     (mclk),
        .rstn     (rstn),
        .psr      (psr_r),
        .sel16    (ctrl_r[2:0]),
        .sel8     (sib_clock_select),
        .ext_rise (ext_rise),
        .ext_fall (ext_fall),
        .tick16   (tick16),
        .tick8    (tick8)
    );

    // Sibling timer tick, registered for a clean output
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sib_tick_r <= 1'b0;
        end else begin
            sib_tick_r <= tick8;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= 4'h0;
        end else if (wr_ctrl) begin
            ctrl_r <= bus.wdata[3:0];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mask_r <= 2'h0;
        end else if (wr_mask) begin
            mask_r <= bus.wdata[1:0];
        end
    end

    // Held reset halts the divided taps of both timers while software aligns them; the DIV1 and external sources still tick
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tsm_r <= 1'b0;
            psr_r <= 1'b0;
        end else if (wr_gtc) begin
            tsm_r <= bus.wdata[`T16_GTC_SYNC];
            psr_r <= bus.wdata[`T16_GTC_PSR] | (psr_r & bus.wdata[`T16_GTC_SYNC]);
        end else if (!tsm_r) begin
            psr_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Shared temporary high byte
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            temp_r <= `T16_BYTE_ZERO;
        end else if (wr_cnt_hi || wr_cmp_hi) begin
            temp_r <= bus.wdata;
        end else if (rd_cnt_lo) begin
            temp_r <= cnt_r[15:8];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cmp_r <= `T16_CNT_ZERO;
        end else if (wr_cmp_lo) begin
            cmp_r <= {temp_r, bus.wdata};
        end
    end

    // ----------------------------------------
    // Counter and compare
    // ----------------------------------------
    assign equal     = (cnt_r == cmp_r);
    assign match     = equal && !block_r;
    assign ctc_clear = match && ctrl_r[`T16_CTRL_CTC];
    assign cmp_set   = tick16 && match;
    assign ovf_set   = tick16 && !wr_cnt_lo && !ctc_clear && (cnt_r == `T16_CNT_MAX);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= `T16_CNT_ZERO;
        end else if (wr_cnt_lo) begin
            cnt_r <= {temp_r, bus.wdata};
        end else if (tick16 && ctc_clear) begin
            cnt_r <= `T16_CNT_ZERO;
        end else if (tick16) begin
            cnt_r <= cnt_r + `T16_CNT_ONE;
        end
    end

    // Armed by a counter write, spent by the next timer tick; a stopped timer keeps it armed
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            block_r <= 1'b0;
        end else if (wr_cnt_lo) begin
            block_r <= 1'b1;
        end else if (tick16) begin
            block_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Flags: set beats clear
    // ----------------------------------------
    always_comb begin
        flags_nxt = flags_r;
        if (cmp_vector_done || (wr_flags && bus.wdata[`T16_BIT_CMP])) begin
            flags_nxt[`T16_BIT_CMP] = 1'b0;
        end
        if (ovf_vector_done || (wr_flags && bus.wdata[`T16_BIT_OVF])) begin
            flags_nxt[`T16_BIT_OVF] = 1'b0;
        end
        if (cmp_set) begin
            flags_nxt[`T16_BIT_CMP] = 1'b1;
        end
        if (ovf_set) begin
            flags_nxt[`T16_BIT_OVF] = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flags_r <= 2'h0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cmp_irq_r <= 1'b0;
            ovf_irq_r <= 1'b0;
        end else begin
            cmp_irq_r <= mask_r[`T16_BIT_CMP] && global_irq_en && flags_r[`T16_BIT_CMP];
            ovf_irq_r <= mask_r[`T16_BIT_OVF] && global_irq_en && flags_r[`T16_BIT_OVF];
        end
    end

    // ----------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= `T16_BYTE_ZERO;
        end else if (bus.rd) begin
            unique case (bus.addr)
                `T16_ADDR_FLAGS:  rdata_r <= {6'h00, flags_r};
                `T16_ADDR_MASK:   rdata_r <= {6'h00, mask_r};
                `T16_ADDR_CTRL:   rdata_r <= {4'h0, ctrl_r};
                `T16_ADDR_GTC:    rdata_r <= {tsm_r, 6'h00, psr_r};
                `T16_ADDR_CNT_LO: rdata_r <= cnt_r[7:0];
                `T16_ADDR_CNT_HI: rdata_r <= temp_r;
                `T16_ADDR_CMP_LO: rdata_r <= cmp_r[7:0];
                `T16_ADDR_CMP_HI: rdata_r <= cmp_r[15:8];
                default:          rdata_r <= `T16_BYTE_ZERO;
            endcase
        end else begin
            rdata_r <= `T16_BYTE_ZERO;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_blocked_equal;
        block_r && (cnt_r == cmp_r) && !flags_r[`T16_BIT_CMP];
    endsequence
    sequence s_next_tick;
        tick16 && !wr_cnt_lo;
    endsequence

    a_write_blocks_match: assert property (
        s_blocked_equal ##0 s_next_tick |=> !flags_r[`T16_BIT_CMP])
        else $error("match after counter write not blocked");

    a_ctrl_reserved: assert property (
        hit(bus.rd, bus.addr, `T16_ADDR_CTRL) |=> rdata_r[7:4] == 4'h0)
        else $error("control reserved bits not zero");

    a_ctc_clears: assert property (
        tick16 && ctc_clear && !wr_cnt_lo |=> cnt_r == `T16_CNT_ZERO)
        else $error("clear on compare failed");

    a_cnt_load: assert property (
        wr_cnt_lo |=> cnt_r == {$past(temp_r), $past(bus.wdata)})
        else $error("counter write lost");

    a_temp_latch: assert property (
        rd_cnt_lo && !wr_cnt_hi && !wr_cmp_hi |=> temp_r == $past(cnt_r[15:8]))
        else $error("temporary byte not latched");

    a_cmp_hi_direct: assert property (
        hit(bus.rd, bus.addr, `T16_ADDR_CMP_HI) && !bus.wr |=>
            rdata_r == $past(cmp_r[15:8]) && $stable(temp_r))
        else $error("compare high read wrong");

    a_match_flag: assert property (
        cmp_set ##1 (!cmp_vector_done && !wr_flags)[*2] |-> flags_r[`T16_BIT_CMP])
        else $error("match flag not kept");

    a_ovf_flag: assert property (
        tick16 && cnt_r == `T16_CNT_MAX && !wr_cnt_lo && !ctc_clear |=>
            flags_r[`T16_BIT_OVF] && cnt_r == `T16_CNT_ZERO)
        else $error("overflow not flagged");

    a_cmp_irq: assert property (
        mask_r[`T16_BIT_CMP] && global_irq_en && flags_r[`T16_BIT_CMP] |=> cmp_irq_r)
        else $error("compare interrupt missing");

    a_ovf_irq: assert property (
        !mask_r[`T16_BIT_OVF] |=> !ovf_irq_r)
        else $error("masked overflow interrupt raised");
    a_psr_clear: assert property (
        psr_r && !tsm_r && !wr_gtc |=> !psr_r ##1 (!psr_r || $past(wr_gtc)))
        else $error("prescaler reset did not self clear");
    a_stop_holds: assert property (
        ctrl_r[2:0] == `T16_CS_STOP && !wr_cnt_lo && !wr_ctrl |=> $stable(cnt_r))
        else $error("stopped counter moved");

endmodule

/* tb/t16_cpu_model.sv */
// Purpose: Model of the CPU side of the timer's I/O register bus
// Assumes: Strobes last one cycle; read data is taken the cycle after
// Notes:   Released address carries the inverted value; a write release inverts the data, a read release keeps the last data
module t16_cpu_model
    import t16_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic [7:0] rdata_r,
    output t16_bus_t        bus,
    output logic            global_irq_en,
    output logic            cmp_vector_done,
    output logic            ovf_vector_done
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bus = '0;
        global_irq_en = 1'b0;
        cmp_vector_done = 1'b0;
        ovf_vector_done = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= {1'b1, 1'b0, a, d};
        @(posedge mclk);
        bus <= {1'b0, 1'b0, ~a, ~d};
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus <= {1'b0, 1'b1, a, ~bus.wdata};
        @(posedge mclk);
        bus <= {1'b0, 1'b0, ~a, bus.wdata};
        #1;
        d = rdata_r;
    endtask

    // High byte first: the low write moves both bytes at once
    task automatic wr16(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] v);
        wr(hi, v[15:8]);
        wr(lo, v[7:0]);
    endtask

    // Low byte first: it latches the high byte into the shared temp
    task automatic rd16(input logic [7:0] lo, input logic [7:0] hi, output logic [15:0] v);
        rd(lo, v[7:0]);
        rd(hi, v[15:8]);
    endtask

    task automatic gie(input logic e);
        @(posedge mclk);
        global_irq_en <= e;
    endtask

    task automatic vec(input logic ovf);
        @(posedge mclk);
        cmp_vector_done <= !ovf;
        ovf_vector_done <= ovf;
        @(posedge mclk);
        cmp_vector_done <= 1'b0;
        ovf_vector_done <= 1'b0;
    endtask
endmodule

/* tb/t16_timer_tb.sv */
// Purpose: Self-checking bench of the 16-bit timer and shared prescaler
// Assumes: CPU model drives the bus; bench drives pin and sibling select
// Notes:   Expected counts come from exact windows of whole prescaler periods
`include "t16_regs.svh"

module t16_timer_tb
    import t16_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] fl = `T16_ADDR_FLAGS;
    localparam logic [7:0] gt = `T16_ADDR_GTC;
    localparam logic [7:0] mk = `T16_ADDR_MASK;
    localparam logic [7:0] ct = `T16_ADDR_CTRL;
    localparam logic [7:0] nl = `T16_ADDR_CNT_LO;
    localparam logic [7:0] nh = `T16_ADDR_CNT_HI;
    localparam logic [7:0] cl = `T16_ADDR_CMP_LO;
    localparam logic [7:0] ch = `T16_ADDR_CMP_HI;

    logic        mclk;
    logic        rstn;
    logic        pin;
    logic [2:0]  sib_sel;
    t16_bus_t    bus;
    logic        gie;
    logic        cvd;
    logic        ovd;
    logic [7:0]  rdata;
    logic        cirq;
    logic        oirq;
    logic        stick;
    logic [15:0] v;
    int          c;
    int          fail_count;
    int          checks;
    int          pdiv[6] = '{8, 32, 64, 128, 256, 1024};

    t16_cpu_model u_t16_cpu_model (.mclk(mclk), .rdata_r(rdata), .bus(bus),
        .global_irq_en(gie), .cmp_vector_done(cvd), .ovf_vector_done(ovd));

    t16_timer u_t16_timer (.mclk(mclk), .rstn(rstn), .bus(bus), .global_irq_en(gie),
        .cmp_vector_done(cvd), .ovf_vector_done(ovd), .external_count_pin(pin),
        .sib_clock_select(sib_sel), .rdata_r(rdata), .cmp_irq_r(cirq),
        .ovf_irq_r(oirq), .sib_tick_r(stick));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Ends just past the edge so registered outputs read settled
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic w(input logic [7:0] a, input logic [7:0] d);
        u_t16_cpu_model.wr(a, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] b;
        u_t16_cpu_model.rd(a, b);
        chk({8'h00, b}, {8'h00, exp});
    endtask

    task automatic ticks(input int n, output int k);
        k = 0;
        repeat (n) begin
            @(posedge mclk);
            #1;
            if (stick === 1'b1) k++;
        end
    endtask

    // Pin half periods stay well above one clock
    task automatic ext(input logic lvl, input int exp);
        int k;
        @(posedge mclk);
        pin <= lvl;
        ticks(2, k);
        chk(16'(k), 16'h0000);
        ticks(6, k);
        chk(16'(k), 16'(exp));
    endtask

    task automatic conclude;
        $display("Mismatches %0d, comparisons %0d", fail_count, checks);
        if (fail_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rc(mk, 8'h00);
        w(mk, 8'hff);
        rc(mk, 8'h03);
        w(mk, 8'h00);
        w(ct, 8'hf8);
        rc(ct, 8'h08);
        w(ct, 8'h00);
        rc(8'h50, 8'h00);
        rc(fl, 8'h00);
    endtask

    task automatic t_rw16;
        u_t16_cpu_model.wr16(ch, cl, 16'h1234);
        w(nh, 8'h55);
        rc(ch, 8'h12);
        rc(cl, 8'h34);
        w(nl, 8'hff);
        u_t16_cpu_model.rd16(nl, nh, v);
        chk(v, 16'h55ff);
    endtask

    task automatic t_block;
        u_t16_cpu_model.wr16(ch, cl, 16'h0010);
        u_t16_cpu_model.wr16(nh, nl, 16'h0010);
        w(ct, 8'h01);
        u_t16_cpu_model.wr16(nh, nl, 16'h0200);
        w(ct, 8'h00);
        rc(fl, 8'h00);
        u_t16_cpu_model.rd16(nl, nh, v);
        chk(v, 16'h0202);
    endtask

    task automatic t_ctc;
        u_t16_cpu_model.wr16(nh, nl, 16'h0000);
        u_t16_cpu_model.wr16(ch, cl, 16'h0005);
        w(ct, 8'h09);
        cyc(20);
        w(ct, 8'h00);
        u_t16_cpu_model.rd16(nl, nh, v);
        chk({15'h0000, v <= 16'h0005}, 16'h0001);
        rc(fl, 8'h02);
        w(mk, 8'h02);
        cyc(3);
        chk({15'h0000, cirq}, 16'h0000);
        u_t16_cpu_model.gie(1'b1);
        cyc(3);
        chk({15'h0000, cirq}, 16'h0001);
        u_t16_cpu_model.vec(1'b0);
        cyc(2);
        rc(fl, 8'h00);
        chk({15'h0000, cirq}, 16'h0000);
    endtask

    task automatic t_ovf;
        u_t16_cpu_model.wr16(nh, nl, 16'hfffe);
        w(ct, 8'h01);
        w(ct, 8'h00);
        u_t16_cpu_model.rd16(nl, nh, v);
        chk(v, 16'h0000);
        rc(fl, 8'h01);
        w(mk, 8'h01);
        cyc(3);
        chk({15'h0000, oirq}, 16'h0001);
        w(fl, 8'h01);
        cyc(2);
        rc(fl, 8'h00);
        chk({15'h0000, oirq}, 16'h0000);
        u_t16_cpu_model.gie(1'b0);
        w(mk, 8'h00);
    endtask

    // Start-to-stop span is exactly four periods of each tap
    task automatic t_pre;
        for (int i = 0; i < 6; i++) begin
            u_t16_cpu_model.wr16(nh, nl, 16'h0000);
            w(ct, {5'h00, 3'(i + 2)});
            cyc(4 * pdiv[i] - 2);
            w(ct, 8'h00);
            u_t16_cpu_model.rd16(nl, nh, v);
            chk(v, 16'h0004);
        end
    endtask

    task automatic t_psr;
        @(posedge mclk);
        sib_sel <= 3'h2;
        cyc(4);
        ticks(64, c);
        chk(16'(c), 16'h0008);
        w(gt, 8'h81);
        cyc(3);
        ticks(40, c);
        chk(16'(c), 16'h0000);
        rc(gt, 8'h81);
        w(gt, 8'h00);
        rc(gt, 8'h00);
        w(gt, 8'h01);
        cyc(2);
        rc(gt, 8'h00);
    endtask

    task automatic t_ext;
        @(posedge mclk);
        sib_sel <= 3'h7;
        cyc(4);
        ext(1'b1, 1);
        ext(1'b0, 0);
        @(posedge mclk);
        sib_sel <= 3'h6;
        cyc(4);
        ext(1'b1, 0);
        ext(1'b0, 1);
        w(gt, 8'h81);
        ext(1'b1, 0);
        ext(1'b0, 1);
        w(gt, 8'h00);
    endtask

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial begin
        rstn = 1'b0;
        pin = 1'b0;
        sib_sel = 3'h0;
        fail_count = 0;
        checks = 0;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        t_regs();
        t_rw16();
        t_block();
        t_ctc();
        t_ovf();
        t_pre();
        t_psr();
        t_ext();
        conclude();
    end

    // Run needs about 6500 cycles
    initial begin
        repeat (40000) @(posedge mclk);
        fail_count++;
        conclude();
    end
endmodule
